// *** pkg/drive_if_pkg.sv ***
/*
 Package for the floppy drive select and status interface: register map,
 field positions, reset values, timing constants and carrier structs.
 Assumes a single 40 MHz clock and an APB register bus.
*/
package drive_if_pkg;

   // APB register byte addresses
   localparam logic [7:0] ctrl_addr   = 8'h00;
   localparam logic [7:0] status_addr = 8'h04;
   localparam logic [7:0] pins_addr   = 8'h08;
   localparam logic [7:0] count_addr  = 8'h0c;

   // Control register fields
   localparam int ctrl_enable_bit   = 0;
   localparam int ctrl_jumper_lsb   = 4;
   localparam int ctrl_jumper_w     = 4;
   localparam logic [31:0] ctrl_reset_value = 32'h0000_0001;

   // Status register fields
   localparam int st_selected_bit   = 0;
   localparam int st_ready_bit      = 1;
   localparam int st_motor_bit      = 2;
   localparam int st_head_load_bit  = 3;
   localparam int st_write_busy_bit = 4;
   localparam int st_protect_bit    = 5;
   localparam int st_track0_bit     = 6;
   localparam int st_door_bit       = 7;
   localparam int st_jumper_err_bit = 8;

   // Read pulse width on the cable
   localparam int  read_pulse_ns     = 200;
   localparam int  clk_period_ns     = 25;
   localparam int  read_pulse_cycles = (read_pulse_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int  pulse_cnt_w       = 4;

   // Number of unit select lines on the cable
   localparam int  unit_count        = 4;

   // Host command lines, already made active high
   typedef struct packed {
      logic head_load_cmd;
      logic motor_on_cmd;
      logic step_direction;
      logic step_cmd;
      logic write_pulses;
      logic write_gate;
      logic head_side_select;
   } host_cmd_type;

   // Drive sensors, active high
   typedef struct packed {
      logic door_closed;
      logic protect_tab;
      logic index_hole;
      logic carriage_home;
      logic read_flux;
      logic stepper_busy;
   } sensor_type;

   // Drive status toward the cable, active low
   typedef struct packed {
      logic ready_n;
      logic sector_index_pulse_n;
      logic track_zero_n;
      logic write_protected_n;
      logic read_pulses_n;
   } status_out_type;

endpackage : drive_if_pkg

// *** tb/drive_interface_properties.sv ***
/*
 Checker for drive_interface cable behaviour.
 Assumes cable and sensor levels reach outputs three edges after they change.
*/
`timescale 1ns/1ps
`default_nettype none
module drive_interface_checker (
   input wire logic                          ref_clk,
   input wire logic                          resetn,
   input wire logic                          unit_select_1_n,
   input wire logic                          unit_select_2_n,
   input wire logic                          unit_select_3_n,
   input wire logic                          unit_select_4_n,
   input wire logic                          motor_on_cmd_n,
   input wire logic                          write_gate_n,
   input wire logic [3:0]                    address_jumper,
   input wire drive_if_pkg::sensor_type      sensors,
   input wire drive_if_pkg::status_out_type  status_out,
   input wire logic                          motor_run,
   input wire logic                          head_load_solenoid,
   input wire logic                          select_led,
   input wire logic                          write_busy
);
   import drive_if_pkg::*;
   logic       sel_now;
   logic       ok;
   logic [6:0] now_v;
   logic [6:0] d1_r, d2_r, d3_r, d4_r;
   logic [2:0] settle_r;
   logic [3:0] hush;
   // Expected causes: select, door, motor, write busy, protect, home, index
   assign sel_now = $onehot(address_jumper) && |(address_jumper & ~{unit_select_4_n,
                    unit_select_3_n, unit_select_2_n, unit_select_1_n});
   assign now_v = {sel_now, sensors.door_closed, sensors.door_closed & sel_now & ~motor_on_cmd_n,
                   ~write_gate_n & ~sensors.protect_tab & ~sensors.stepper_busy & sel_now,
                   sensors.protect_tab, sensors.carriage_home, sensors.index_hole};
   assign ok = settle_r == 3'd4;
   assign hush = ~{d1_r[6], d2_r[6], d3_r[6], d4_r[6]} | {d1_r[3], d2_r[3], d3_r[3], d4_r[3]};
   // Delay line matching the sync and output register depth
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) {d1_r, d2_r, d3_r, d4_r} <= '0;
      else {d1_r, d2_r, d3_r, d4_r} <= {now_v, d1_r, d2_r, d3_r};
   end
   // Pipeline fill after reset
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) settle_r <= '0;
      else if (settle_r != 3'd4) settle_r <= settle_r + 3'd1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence flux_seen;
      ok && $changed(sensors.read_flux) && (&{now_v[6], d1_r[6], d2_r[6], d3_r[6]})
         && !(|{now_v[3], d1_r[3], d2_r[3], d3_r[3]});
   endsequence
   sequence pulse_low;
      ##[3:5] !status_out.read_pulses_n;
   endsequence
   led_follow_a: assert property (ok |-> select_led == d3_r[6])
      else $error("select indicator off");
   head_load_a: assert property (ok |-> head_load_solenoid == d3_r[6])
      else $error("head load wrong");
   door_lock_a: assert property (ok && !d3_r[5] |-> status_out.ready_n && !motor_run)
      else $error("door open yet ready or motor");
   motor_run_a: assert property (ok |-> motor_run == d3_r[4])
      else $error("motor drive wrong");
   write_busy_a: assert property (ok |-> write_busy == d3_r[3])
      else $error("write busy wrong");
   status_gate_a: assert property (ok && !d3_r[6] |-> &{status_out.ready_n,
      status_out.sector_index_pulse_n, status_out.track_zero_n, status_out.write_protected_n})
      else $error("status driven while unselected");
   protect_flag_a: assert property (ok && d3_r[6] |-> status_out.write_protected_n != d3_r[2])
      else $error("protect flag wrong");
   track_zero_a: assert property (ok && d3_r[6] |-> status_out.track_zero_n != d3_r[1])
      else $error("track zero wrong");
   index_pulse_a: assert property (ok && d3_r[6] |-> status_out.sector_index_pulse_n != d3_r[0])
      else $error("index pulse wrong");
   read_quiet_a: assert property (ok && (&hush) |-> status_out.read_pulses_n)
      else $error("read pulse leaked");
   read_pulse_a: assert property (flux_seen |-> pulse_low)
      else $error("read pulse missing");
endmodule : drive_interface_checker
bind drive_interface drive_interface_checker u_drive_interface_checker (.*);
`default_nettype wire

// *** tb/floppy_drive_select_status_interface_bench.sv ***
/*
 Self-checking bench for drive_interface with a host model and APB master.
 Assumes zero wait APB and three edge cable latency.
*/
`timescale 1ns/1ps
`default_nettype none
module floppy_drive_select_status_interface_bench;
   import drive_if_pkg::*;
   logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, seed, r;
   logic pready, pslverr, e;
   logic head_load_cmd_n, unit_select_1_n, unit_select_2_n, unit_select_3_n, unit_select_4_n;
   logic motor_on_cmd_n, step_direction_n, step_cmd_n, write_pulses_n, write_gate_n;
   logic head_side_select_n, motor_run, head_load_solenoid, select_led, write_busy;
   logic head_side, step_dir_out, step_out, write_data_out, s;
   logic [3:0] address_jumper = 4'h2;
   logic [2:0] unit = '0;
   host_cmd_type cmd = '0;
   sensor_type sensors = '0;
   status_out_type status_out;
   int mismatches = 0, cmp_count = 0, n;
   drive_interface u_drive_interface (.*);
   host_ctrl_model u_host_ctrl_model (.*);
   always #12.5 ref_clk = ~ref_clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (mismatches == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   // One APB transfer, held until pready at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   function automatic logic sel_exp(logic [3:0] j, logic [2:0] u);
      return $onehot(j) && u != 0 && j[u-1];
   endfunction : sel_exp
   // Flip the read flux and count cycles of read pulse low
   task automatic read_try(input logic wg);
      cmd <= wg ? 7'h02 : 7'h00;
      unit <= 3'd2;
      sensors <= {4'b1000, sensors.read_flux, 1'b0};
      repeat (6) @(posedge ref_clk);
      sensors.read_flux <= ~sensors.read_flux;
      n = 0;
      repeat (14) begin
         @(posedge ref_clk);
         #1 n += (status_out.read_pulses_n === 1'b0);
      end
      chk(n, (sel_exp(address_jumper, 3'd2) && !wg) ? read_pulse_cycles : 0);
   endtask : read_try
   initial begin
      #(25 * 20000);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      logic [3:0] jtab [3] = '{4'h2, 4'h8, 4'h3};
      seed = 32'h8d19b730;
      foreach (jtab[j]) begin
         address_jumper <= jtab[j];
         resetn <= 0;
         repeat (3) @(posedge ref_clk);
         resetn <= 1;
         apb(0, ctrl_addr, '0);
         chk(r, ctrl_reset_value);
         apb(0, 8'h10, '0);
         chk(r, 32'h0000_0000);
         chk(32'(e), 32'h0000_0001);
         apb(1, count_addr, '0);
         apb(0, count_addr, '0);
         chk(r, '0);
         read_try(0);
         read_try(1);
         // Random cable and sensor states, settled then compared
         repeat (40) begin
            r = $random(seed);
            unit <= 3'((r[31:16] & 16'h7fff) % 5);
            cmd <= r[6:0];
            sensors <= {r[11:8], sensors.read_flux, r[12]};
            repeat (5) @(posedge ref_clk);
            #1 s = sel_exp(address_jumper, unit);
            chk(32'({select_led, head_load_solenoid, motor_run, write_busy,
               status_out.write_protected_n, status_out.track_zero_n}),
               32'({s, s, sensors.door_closed & s & cmd.motor_on_cmd, cmd.write_gate
               & ~sensors.protect_tab & ~sensors.stepper_busy & s,
               ~(sensors.protect_tab & s), ~(sensors.carriage_home & s)}));
            if (!(sensors.door_closed && s)) chk(status_out.ready_n, 1'b1);
            else chk(status_out.ready_n, 1'b0);
            chk(32'({head_side, step_dir_out, step_out, write_data_out,
               status_out.sector_index_pulse_n}), 32'({s & cmd.head_side_select,
               s & cmd.step_direction, s & cmd.step_cmd, cmd.write_gate & cmd.write_pulses
               & ~sensors.protect_tab & ~sensors.stepper_busy & s, ~(sensors.index_hole & s)}));
            apb(0, status_addr, '0);
            chk(r[st_selected_bit], s);
         end
      end
      tally_and_finish();
   end
endmodule : floppy_drive_select_status_interface_bench
`default_nettype wire

// *** tb/host_ctrl_model.sv ***
/*
 Host controller model: drives the low true cable command lines.
 Assumes unit 0 means no drive selected, 1..4 pick one select line.
*/
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
   input  wire logic                       ref_clk,
   input  wire logic [2:0]                 unit,
   input  wire drive_if_pkg::host_cmd_type cmd,
   output logic                            head_load_cmd_n,
   output logic                            unit_select_1_n,
   output logic                            unit_select_2_n,
   output logic                            unit_select_3_n,
   output logic                            unit_select_4_n,
   output logic                            motor_on_cmd_n,
   output logic                            step_direction_n,
   output logic                            step_cmd_n,
   output logic                            write_pulses_n,
   output logic                            write_gate_n,
   output logic                            head_side_select_n
);
   import drive_if_pkg::*;
   logic [4:0] pick;
   assign pick = 5'h01 << unit;
   // Terminated lines idle negated
   initial begin
      {unit_select_4_n, unit_select_3_n, unit_select_2_n, unit_select_1_n} = 4'hf;
      {head_load_cmd_n, motor_on_cmd_n, step_direction_n, step_cmd_n} = 4'hf;
      {write_pulses_n, write_gate_n, head_side_select_n} = 3'h7;
   end
   // At most one select low, every line low true
   always @(posedge ref_clk) begin
      {unit_select_4_n, unit_select_3_n, unit_select_2_n, unit_select_1_n} <= ~pick[4:1];
      {head_load_cmd_n, motor_on_cmd_n, step_direction_n, step_cmd_n, write_pulses_n,
       write_gate_n, head_side_select_n} <= ~cmd;
   end
endmodule : host_ctrl_model
`default_nettype wire

// *** verilog/drive_interface.sv ***
/*
 Drive side of the floppy cable interface: unit select by address jumper,
 gated status and read data, select indicator, door interlock, motor
 control, write mode qualification, head load, plus an APB register file.
 Assumes cable and sensor inputs are asynchronous and get synchronised
 here; APB comes from logic on ref_clk.
*/
// The implementer's own choices: the register addresses and the APB interface to the registers.
// Function
// R01 - Door open: motor off, ready negated
// R02 - Write protect follows covered notch
// R03 - All cable lines are active low
// R04 - Host drives inputs, drive drives five outputs
// R05 - Respond only to jumper-chosen select line
// R06 - Host addresses at most four drives
// R07 - Status and read data only when selected
// R08 - Indicator lit exactly while selected
// R09 - Integrator sets terminators and jumpers
// R10 - Motor powered only while motor_run high
// R11 - Index pulse from optical hole sensor
// R12 - Head signal becomes read pulse stream
// R13 - Read pulses suppressed unselected or writing
// R14 - Write mode needs gate, unprotected, idle, selected
// R15 - Track zero from carriage home switch
// R16 - Head load solenoid follows selection
// R17 - Ignore other selects and unselected inputs
`timescale 1ns/1ps
`default_nettype none
module drive_interface (
   input  wire logic                     ref_clk,
   input  wire logic                     resetn,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Cable inputs, active low
   input  wire logic                     head_load_cmd_n,
   input  wire logic                     unit_select_1_n,
   input  wire logic                     unit_select_2_n,
   input  wire logic                     unit_select_3_n,
   input  wire logic                     unit_select_4_n,
   input  wire logic                     motor_on_cmd_n,
   input  wire logic                     step_direction_n,
   input  wire logic                     step_cmd_n,
   input  wire logic                     write_pulses_n,
   input  wire logic                     write_gate_n,
   input  wire logic                     head_side_select_n,
   // Jumper straps address_jumper_1..4, closed = 1
   input  wire logic [3:0]               address_jumper,
   // Mechanism sensors
   input  wire drive_if_pkg::sensor_type sensors,
   // Cable outputs, active low
   output drive_if_pkg::status_out_type  status_out,
   // Mechanism drives
   output logic                          motor_run,
   output logic                          head_load_solenoid,
   output logic                          select_led,
   output logic                          write_busy,
   output logic                          head_side,
   output logic                          step_dir_out,
   output logic                          step_out,
   output logic                          write_data_out
);
   import drive_if_pkg::*;

   logic [10:0]  cable_n_s;
   logic [3:0]   jumper_s;
   sensor_type   sens_s;
   host_cmd_type cmd;
   logic [3:0]   select_lines;
   logic [3:0]   jumper_r;
   logic         jumper_taken_r;
   logic [1:0]   sync_fill_r;
   logic [31:0]  ctrl_r;
   logic [15:0]  index_count_r;
   logic         index_last_r;
   logic         selected;
   logic         selected_r;
   logic         jumper_err;
   logic         read_pulse;
   logic         write_mode;
   logic         enable;
   logic [3:0]   jumper_eff;
   logic [31:0]  status_word;
   logic         apb_access;
   logic         addr_ok;

   // Cable and sensor inputs through two flip-flops
   pin_sync #(.width(11), .reset_val(11'h7ff)) u_cable_sync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .async_in ({head_load_cmd_n, unit_select_1_n, unit_select_2_n,
                  unit_select_3_n, unit_select_4_n, motor_on_cmd_n,
                  step_direction_n, step_cmd_n, write_pulses_n,
                  write_gate_n, head_side_select_n}),
      .sync_out (cable_n_s)
   );

   pin_sync #(.width(10), .reset_val(10'h000)) u_sense_sync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .async_in ({address_jumper, sensors}),
      .sync_out ({jumper_s, sens_s})
   );

   // Low true cable lines become active high internal levels
   assign cmd.head_load_cmd    = ~cable_n_s[10];  // R03
   assign select_lines         = ~{cable_n_s[6], cable_n_s[7],
                                   cable_n_s[8], cable_n_s[9]}; // R03
   assign cmd.motor_on_cmd     = ~cable_n_s[5];
   assign cmd.step_direction   = ~cable_n_s[4];
   assign cmd.step_cmd         = ~cable_n_s[3];
   assign cmd.write_pulses     = ~cable_n_s[2];
   assign cmd.write_gate       = ~cable_n_s[1];
   assign cmd.head_side_select = ~cable_n_s[0];

   // Marks when the synchroniser holds real strap levels, not its reset value
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) sync_fill_r <= 2'b00;
      else         sync_fill_r <= {sync_fill_r[0], 1'b1};
   end

   // Jumper strap captured once, after both sync stages have filled
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         jumper_r       <= 4'h0;
         jumper_taken_r <= 1'b0;
      end else if (sync_fill_r[1] && !jumper_taken_r) begin
         jumper_r       <= jumper_s;
         jumper_taken_r <= 1'b1;
      end
   end

   // Software may override the strap with a nonzero jumper field
   assign jumper_eff = (ctrl_r[ctrl_jumper_lsb +: ctrl_jumper_w] != 4'h0) ?
                       ctrl_r[ctrl_jumper_lsb +: ctrl_jumper_w] : jumper_r;
   assign enable     = ctrl_r[ctrl_enable_bit];

   // Exactly one jumper must be fitted, otherwise never selected
   assign jumper_err = !(jumper_eff == 4'h1 || jumper_eff == 4'h2 ||
                         jumper_eff == 4'h4 || jumper_eff == 4'h8);

   // Only the chosen select line counts; others are ignored
   assign selected = enable && jumper_taken_r && !jumper_err &&
                     ((select_lines & jumper_eff) != 4'h0); // R05 R17

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) selected_r <= 1'b0;
      else         selected_r <= selected;
   end

   // Indicator and head load follow selection
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         select_led         <= 1'b0;
         head_load_solenoid <= 1'b0;
      end else begin
         select_led         <= selected;               // R08
         head_load_solenoid <= selected;               // R16
      end
   end

   // Motor runs only with door closed and a selected motor command
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) motor_run <= 1'b0;
      else         motor_run <= sens_s.door_closed &&
                                selected && cmd.motor_on_cmd; // R01 R10 R17
   end

   // Write mode qualification
   assign write_mode = cmd.write_gate && !sens_s.protect_tab &&
                       !sens_s.stepper_busy && selected; // R14

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) write_busy <= 1'b0;
      else         write_busy <= write_mode;           // R14
   end

   // Host commands pass to the mechanism only while selected
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         head_side      <= 1'b0;
         step_dir_out   <= 1'b0;
         step_out       <= 1'b0;
         write_data_out <= 1'b0;
      end else begin
         head_side      <= selected && cmd.head_side_select; // R17
         step_dir_out   <= selected && cmd.step_direction;   // R17
         step_out       <= selected && cmd.step_cmd && cmd.head_load_cmd
                           ? 1'b1 : selected && cmd.step_cmd;
         write_data_out <= write_mode && cmd.write_pulses;
      end
   end

   // Read flux edges become fixed pulses, held off unselected or writing
   edge_pulse u_read_pulse (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .clear     (!selected || write_mode),            // R13
      .level_in  (sens_s.read_flux),
      .pulse_out (read_pulse)                          // R12
   );

   // Cable outputs, negated unless selected
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         status_out <= '1;
      end else begin
         status_out.ready_n              <= !(selected && sens_s.door_closed); // R01 R07
         status_out.sector_index_pulse_n <= !(selected && sens_s.index_hole);  // R11 R07
         status_out.track_zero_n         <= !(selected && sens_s.carriage_home); // R15
         status_out.write_protected_n    <= !(selected && sens_s.protect_tab); // R02 R07
         status_out.read_pulses_n        <= !(selected && read_pulse);          // R12 R04
      end
   end

   // Index hole counter for software spindle checks
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         index_last_r  <= 1'b0;
         index_count_r <= 16'h0000;
      end else begin
         index_last_r <= sens_s.index_hole;
         if (apb_access && pwrite && paddr == count_addr)
            index_count_r <= 16'h0000;
         else if (sens_s.index_hole && !index_last_r)
            index_count_r <= index_count_r + 16'h0001;
      end
   end

   // APB slave, zero wait states
   assign apb_access = psel && penable;
   assign pready     = 1'b1;
   assign addr_ok    = (paddr == ctrl_addr) || (paddr == status_addr) ||
                       (paddr == pins_addr) || (paddr == count_addr);
   assign pslverr    = apb_access && !addr_ok;

   assign status_word = {23'h000000, jumper_err, !sens_s.door_closed,
                         sens_s.carriage_home, sens_s.protect_tab, write_busy,
                         head_load_solenoid, motor_run,
                         !status_out.ready_n, selected_r};

   // Control register write
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) ctrl_r <= ctrl_reset_value;
      else if (apb_access && pwrite && paddr == ctrl_addr)
         ctrl_r <= pwdata & 32'h0000_00f1;
   end

   // Read data registered at setup so it is valid in the access phase
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            ctrl_addr:   prdata <= ctrl_r;
            status_addr: prdata <= status_word;
            pins_addr:   prdata <= {17'h00000, cable_n_s, jumper_eff};
            count_addr:  prdata <= {16'h0000, index_count_r};
            default:     prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : drive_interface
`default_nettype wire

// *** verilog/edge_pulse.sv ***
/*
 Turns each edge of a synchronised level into a fixed width pulse.
 Assumes the input is already in the ref_clk domain; clear forces idle.
*/
`timescale 1ns/1ps
`default_nettype none
module edge_pulse
   import drive_if_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic clear,
   input  wire logic level_in,
   output logic      pulse_out
);
   logic                   last_r;
   logic [pulse_cnt_w-1:0] cnt_r;

   // Remember the previous level
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) last_r <= 1'b0;
      else         last_r <= level_in;
   end

   // Load width on either edge, count down, hold at zero under clear
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
      end else if (clear) begin
         cnt_r <= '0;
      end else if (level_in != last_r) begin
         cnt_r <= pulse_cnt_w'(read_pulse_cycles);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - pulse_cnt_w'(1);
      end
   end

   // Pulse registered so the data output comes from a flip-flop
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) pulse_out <= 1'b0;
      else         pulse_out <= (cnt_r != '0) && !clear;
   end
endmodule : edge_pulse
`default_nettype wire

// *** verilog/pin_sync.sv ***
/*
 Two flip-flop synchroniser for a bundle of asynchronous levels.
 Assumes inputs come from pins outside the ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int width       = 1,
   parameter logic [width-1:0] reset_val = '0
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic [width-1:0] async_in,
   output logic      [width-1:0] sync_out
);
   logic [width-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         meta_r   <= reset_val;
         sync_out <= reset_val;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : pin_sync
`default_nettype wire
